// File: logic/fpec_ctrl.v
// Flash program/erase controller: AXI4-Lite registers and protection.
`timescale 1ns/1ns
`default_nettype none
`include "fpec_defines.vh"
module fpec_ctrl #(
	parameter PAGE_AW = `FPEC_PAGE_ABITS
) (
	// Clock and resets.
	input wire aclk,
	input wire aresetn,
	input wire por_n,
	// AXI4-Lite write address and data.
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response.
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read.
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Pins.
	input wire write_protect_pin,
	// System status from the CPU side, same clock.
	input wire standby,
	input wire boot_running,
	input wire flash_read,
	input wire exception_taken,
	input wire sleep_exec,
	// Flash array side: page writes and verify reads.
	input wire flash_wr,
	input wire [17:0] flash_wr_addr,
	input wire [7:0] flash_wr_data,
	input wire [PAGE_AW-1:0] latch_rd_addr,
	output reg [7:0] latch_rd_data,
	output reg [17:0] page_base,
	// Array controls.
	output reg prog_active,
	output reg erase_active,
	output reg [15:0] erase_blocks,
	output reg pverify_mode,
	output reg everify_mode,
	output reg verify_dummy_seen,
	output reg irq_block
);
	reg [7:0] ctrl1_reg;
	reg [7:0] ebs1_reg;
	reg [7:0] ebs2_reg;
	reg [7:0] ovl_reg;
	reg err_reg;
	reg [7:0] page_cnt_reg;
	reg aw_hold_reg;
	reg w_hold_reg;
	reg [11:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	wire wp_sync;
	wire [7:0] mem_rd;
	wire hw_protect;
	wire err_event;
	wire prog_allow;
	wire erase_allow;
	wire do_write;
	wire addr_ok;
	reg [31:0] rd_mux;
	reg rd_ok;

	// The write-protect pin arrives from outside the clock domain.
	fpec_sync #(
		.W(1)
	) u_wp_sync (
		.aclk(aclk),
		.d_in(write_protect_pin),
		.q_out(wp_sync)
	);

	// Page latch storage; verify dummy writes must not disturb its bytes.
	fpec_page_mem #(
		.DEPTH(`FPEC_PAGE_BYTES),
		.AW(PAGE_AW)
	) u_page (
		.aclk(aclk),
		.wr_en(flash_wr & ~ctrl1_reg[`FPEC_C1_PV] &
			~ctrl1_reg[`FPEC_C1_EV]),
		.wr_addr(flash_wr_addr[PAGE_AW-1:0]),
		.wr_data(flash_wr_data),
		.rd_addr(latch_rd_addr),
		.rd_data(mem_rd)
	);

	assign hw_protect = wp_sync | standby;
	assign err_event = (prog_active | erase_active) &
		(flash_read | exception_taken | sleep_exec);
	assign prog_allow = ctrl1_reg[`FPEC_C1_PROG] &
		ctrl1_reg[`FPEC_C1_UNLOCK] & ~ovl_reg[`FPEC_OVL_ACT] &
		~err_reg & ~err_event & ~hw_protect;
	assign erase_allow = ctrl1_reg[`FPEC_C1_ERASE] &
		ctrl1_reg[`FPEC_C1_UNLOCK] & ~ovl_reg[`FPEC_OVL_ACT] &
		~err_reg & ~err_event & ~hw_protect &
		((ebs1_reg | ebs2_reg) != 8'h00);

	assign do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
	assign addr_ok = (awaddr_reg[1:0] == 2'b00) &&
		(awaddr_reg <= `FPEC_OFS_STAT);

	// Write channel capture: address and data taken in either order.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			s_axi_awready <= ~aw_hold_reg & ~s_axi_awready;
			s_axi_wready <= ~w_hold_reg & ~s_axi_wready;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= addr_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
			end
		end
	end

	// Control registers; the clear terms come first so protection wins.
	always @(posedge aclk)
	begin
		if (!aresetn || hw_protect)
		begin
			ctrl1_reg <= `FPEC_RST_BYTE;
			ebs1_reg <= `FPEC_RST_BYTE;
			ebs2_reg <= `FPEC_RST_BYTE;
			if (!aresetn)
				ovl_reg <= `FPEC_RST_BYTE;
		end
		else if (do_write && addr_ok && wstrb_reg[0])
		begin
			case (awaddr_reg)
				`FPEC_OFS_CTRL1: ctrl1_reg <= wdata_reg[7:0];
				`FPEC_OFS_EBS1: ebs1_reg <= wdata_reg[7:0];
				`FPEC_OFS_EBS2: ebs2_reg <= wdata_reg[7:0];
				`FPEC_OFS_OVL: ovl_reg <= wdata_reg[7:0];
				default: ;
			endcase
		end
	end

	// Error flag survives every reset but power-on, whose clear has priority.
	always @(posedge aclk)
	begin
		if (!por_n)
			err_reg <= 1'b0;
		else if (err_event)
			err_reg <= 1'b1;
	end

	// Array drive, registered; program and erase run only when allowed, and never together.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prog_active <= 1'b0;
			erase_active <= 1'b0;
			erase_blocks <= 16'h0000;
			pverify_mode <= 1'b0;
			everify_mode <= 1'b0;
			irq_block <= 1'b0;
		end
		else
		begin
			prog_active <= prog_allow & ~erase_allow;
			erase_active <= erase_allow & ~prog_allow;
			erase_blocks <= erase_allow ? {ebs2_reg, ebs1_reg} : 16'h0000;
			pverify_mode <= ctrl1_reg[`FPEC_C1_PV] &
				ctrl1_reg[`FPEC_C1_UNLOCK] & ~hw_protect;
			everify_mode <= ctrl1_reg[`FPEC_C1_EV] &
				ctrl1_reg[`FPEC_C1_UNLOCK] & ~hw_protect;
			irq_block <= prog_allow | erase_allow | boot_running;
		end
	end

	// Page latch address and byte count; a verify dummy write is noted.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			page_base <= 18'h0_0000;
			page_cnt_reg <= 8'h00;
			verify_dummy_seen <= 1'b0;
			latch_rd_data <= 8'h00;
		end
		else
		begin
			latch_rd_data <= mem_rd;
			if (flash_wr && (ctrl1_reg[`FPEC_C1_PV] |
				ctrl1_reg[`FPEC_C1_EV]))
			begin
				verify_dummy_seen <= (flash_wr_data == `FPEC_ERASED_BYTE);
				page_base <= flash_wr_addr;
			end
			else if (flash_wr)
			begin
				if (flash_wr_addr[PAGE_AW-1:0] == {PAGE_AW{1'b0}})
				begin
					page_base <= {flash_wr_addr[17:PAGE_AW],
						{PAGE_AW{1'b0}}};
					page_cnt_reg <= 8'h01;
				end
				else if (page_cnt_reg != 8'hFF)
					page_cnt_reg <= page_cnt_reg + 8'h01;
			end
			if (!ctrl1_reg[`FPEC_C1_PV] && !ctrl1_reg[`FPEC_C1_EV])
				verify_dummy_seen <= verify_dummy_seen & ~flash_wr;
		end
	end

	// Read multiplexer; unmapped offsets answer with a slave error.
	always @*
	begin
		rd_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			`FPEC_OFS_CTRL1: rd_mux[7:0] = ctrl1_reg;
			`FPEC_OFS_CTRL2: rd_mux[`FPEC_C2_ERR] = err_reg;
			`FPEC_OFS_EBS1: rd_mux[7:0] = ebs1_reg;
			`FPEC_OFS_EBS2: rd_mux[7:0] = ebs2_reg;
			`FPEC_OFS_OVL: rd_mux[7:0] = ovl_reg;
			`FPEC_OFS_STAT:
			begin
				rd_mux[`FPEC_ST_PROG] = prog_active;
				rd_mux[`FPEC_ST_ERASE] = erase_active;
				rd_mux[`FPEC_ST_PV] = pverify_mode;
				rd_mux[`FPEC_ST_EV] = everify_mode;
				rd_mux[`FPEC_ST_LOCKED] = err_reg | hw_protect;
				rd_mux[`FPEC_ST_IRQBLK] = irq_block;
				rd_mux[`FPEC_ST_CNT+7:`FPEC_ST_CNT] = page_cnt_reg;
			end
			default: rd_ok = 1'b0;
		endcase
	end

	// Read channel: one cycle to accept, data held until taken.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // fpec_ctrl
`default_nettype wire

// File: logic/fpec_defines.vh
// Program/erase control constants: offsets, fields, reset values, sizes.
`ifndef FPEC_DEFINES_VH
`define FPEC_DEFINES_VH
// Register byte offsets.
`define FPEC_OFS_CTRL1 12'h000
`define FPEC_OFS_CTRL2 12'h004
`define FPEC_OFS_EBS1 12'h008
`define FPEC_OFS_EBS2 12'h00C
`define FPEC_OFS_OVL 12'h010
`define FPEC_OFS_STAT 12'h014
// Fields of flash_ctrl_reg_first.
`define FPEC_C1_PROG 0
`define FPEC_C1_ERASE 1
`define FPEC_C1_PV 2
`define FPEC_C1_EV 3
`define FPEC_C1_UNLOCK 6
`define FPEC_C1_W 7
// Field of flash_ctrl_reg_second.
`define FPEC_C2_ERR 7
// Field of ram_overlay_reg.
`define FPEC_OVL_ACT 3
// Reset values.
`define FPEC_RST_BYTE 8'h00
// Page latch size and start alignment.
`define FPEC_PAGE_BYTES 128
`define FPEC_PAGE_ABITS 7
`define FPEC_ERASED_BYTE 8'hFF
// Status register fields.
`define FPEC_ST_PROG 0
`define FPEC_ST_ERASE 1
`define FPEC_ST_PV 2
`define FPEC_ST_EV 3
`define FPEC_ST_LOCKED 4
`define FPEC_ST_IRQBLK 5
`define FPEC_ST_CNT 6
`endif

// File: logic/fpec_page_mem.v
// Page latch memory for the bytes of one programming unit.
`timescale 1ns/1ns
`default_nettype none
module fpec_page_mem #(
	parameter DEPTH = 128,
	parameter AW = 7
) (
	// Clock.
	input wire aclk,
	// Write port.
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [7:0] wr_data,
	// Registered read port.
	input wire [AW-1:0] rd_addr,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:DEPTH-1];

	// Read data comes out of a register so it can map onto block RAM.
	always @(posedge aclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule // fpec_page_mem
`default_nettype wire

// File: logic/fpec_sync.v
// Two-flip-flop synchroniser for asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
module fpec_sync #(
	parameter W = 1
) (
	// Clock.
	input wire aclk,
	// Asynchronous input and synchronised output.
	input wire [W-1:0] d_in,
	output reg [W-1:0] q_out
);
	reg [W-1:0] meta_reg;

	// First stage feeds only the second stage, to contain metastability.
	always @(posedge aclk)
	begin
		meta_reg <= d_in;
		q_out <= meta_reg;
	end
endmodule // fpec_sync
`default_nettype wire

// File: verification/fpec_ctrl_assertions.sv
// Port checker of the flash program/erase controller.
`timescale 1ns/1ns
`default_nettype none
module fpec_ctrl_chk (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// System status inputs.
	input wire write_protect_pin,
	input wire standby,
	input wire boot_running,
	input wire flash_read,
	input wire exception_taken,
	input wire sleep_exec,
	// Array controls.
	input wire prog_active,
	input wire erase_active,
	input wire [15:0] erase_blocks,
	input wire irq_block
);
	// One clock domain, so the clock and reset are given once.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Helper terms for the active state and the error events.
	wire run = prog_active | erase_active;
	wire bad = flash_read | exception_taken | sleep_exec;
	a_one_mode: assert property (!(prog_active && erase_active))
		else $error("program and erase active together");
	a_error_abort: assert property (run && bad |=> !run)
		else $error("error event did not abort");
	a_boot_irq: assert property (boot_running |-> ##[1:2] irq_block)
		else $error("interrupts open during boot");
	a_run_irq: assert property (run |-> ##[0:2] irq_block)
		else $error("interrupts open during program or erase");
	a_pin_protect: assert property (write_protect_pin [*4] |=> !run)
		else $error("array active under protect pin");
	a_standby_off: assert property (standby [*2] |=> !run)
		else $error("array active in standby");
	a_reset_idle: assert property ($rose(aresetn) |-> !run && !irq_block)
		else $error("outputs not idle after reset");
	a_block_sel: assert property (erase_active |-> |erase_blocks)
		else $error("erase with no block selected");
	// Main scenarios reached.
	c_prog_abort: cover property (prog_active && flash_read);
	c_erase_end: cover property ($fell(erase_active));
	c_standby_run: cover property (standby && prog_active);
endmodule // fpec_ctrl_chk

bind fpec_ctrl fpec_ctrl_chk u_chk (.aclk, .aresetn, .write_protect_pin,
	.standby, .boot_running, .flash_read, .exception_taken, .sleep_exec,
	.prog_active, .erase_active, .erase_blocks, .irq_block);
`default_nettype wire

// File: verification/fpec_tb.sv
// Self-checking bench of the flash program/erase controller.
`timescale 1ns/1ns
`default_nettype none
module tb;
	reg aclk = 0, aresetn = 0, por_n = 0;
	reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg s_axi_arvalid = 0, s_axi_rready = 0;
	reg write_protect_pin = 0, standby = 0, boot_running = 0;
	reg flash_read = 0, exception_taken = 0, sleep_exec = 0, flash_wr = 0;
	reg [17:0] flash_wr_addr = 0;
	reg [7:0] flash_wr_data = 0;
	reg [6:0] latch_rd_addr = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, prog_active, erase_active, pverify_mode;
	wire everify_mode, verify_dummy_seen, irq_block;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] latch_rd_data;
	wire [17:0] page_base;
	wire [15:0] erase_blocks;
	integer errors = 0, total_checks = 0, guard, i, k;
	// Clock of 4 ns.
	always #2 aclk = ~aclk;
	fpec_ctrl DUT (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_protect_pin,
		.standby, .boot_running, .flash_read, .exception_taken, .sleep_exec,
		.flash_wr, .flash_wr_addr, .flash_wr_data, .latch_rd_addr,
		.latch_rd_data, .page_base, .prog_active, .erase_active,
		.erase_blocks, .pverify_mode, .everify_mode, .verify_dummy_seen,
		.irq_block);
	// Verdict and end of run.
	task close_out;
	begin
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	// Compare one result; case equality keeps unknowns from matching.
	task chk(input [31:0] got, input [31:0] exp);
	begin
		total_checks = total_checks + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	// One edge of a bounded wait; a hang ends the run.
	task step;
	begin
		@(posedge aclk);
		guard = guard + 1;
		if (guard > 64)
		begin
			errors = errors + 1;
			close_out;
		end
	end
	endtask
	// Settle for n edges, then step off the edge.
	task wt(input integer n);
	begin
		repeat (n) @(posedge aclk);
		#1;
	end
	endtask
	// Register write; address and data are released as each is taken.
	task wr(input [11:0] a, input [31:0] d, input [1:0] r);
	begin
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		guard = 0;
		while (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid)
		begin
			step;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
	end
	endtask
	// Register read; data is compared only when OKAY is the expected answer.
	task rd(input [11:0] a, input [31:0] d, input [1:0] r);
	begin
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		guard = 0;
		while (s_axi_arvalid || !s_axi_rvalid)
		begin
			step;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rresp, r);
		if (r == 2'h0) chk(s_axi_rdata, d);
	end
	endtask
	// Reset for 12 cycles; p also gives a power-on reset.
	task rst(input p);
	begin
		@(posedge aclk);
		aresetn <= 1'b0;
		por_n <= !p;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		wt(2);
	end
	endtask
	// One-cycle error event of kind k.
	task ev(input integer k);
	begin
		@(posedge aclk);
		flash_read <= (k == 0);
		exception_taken <= (k == 1);
		sleep_exec <= (k == 2);
		@(posedge aclk);
		flash_read <= 1'b0;
		exception_taken <= 1'b0;
		sleep_exec <= 1'b0;
		wt(2);
	end
	endtask
	// Main sequence.
	initial
	begin
		rst(1);
		chk({prog_active, erase_active, irq_block}, 0);
		rd(12'h000, 0, 0);
		rd(12'h020, 0, 2'h2);
		wr(12'h020, 0, 2'h2);
		@(posedge aclk);
		boot_running <= 1'b1;
		wt(3);
		chk(irq_block, 1);
		@(posedge aclk);
		boot_running <= 1'b0;
		wr(12'h000, 32'h0000_0001, 0);
		wt(2);
		chk(prog_active, 0);
		wr(12'h000, 32'h0000_0040, 0);
		// full unit: 128 bytes into the erased unit that starts at 18'h0_0180.
		for (i = 0; i < 128; i = i + 1)
		begin
			@(posedge aclk);
			flash_wr <= 1'b1;
			flash_wr_addr <= 18'h0_0180 + i[17:0];
			flash_wr_data <= 8'hA5 ^ i[7:0];
		end
		@(posedge aclk);
		flash_wr <= 1'b0;
		latch_rd_addr <= 7'h05;
		wt(3);
		chk(page_base, 18'h0_0180);
		chk(latch_rd_data, 8'hA0);
		rd(12'h014, 32'h0000_2000, 0);
		wr(12'h000, 32'h0000_0041, 0);
		wt(2);
		chk({prog_active, irq_block, erase_active}, 3'b110);
		wr(12'h000, 32'h0000_0040, 0);
		wt(2);
		chk(prog_active, 0);
		// Both verify modes with their dummy write.
		for (k = 0; k < 2; k = k + 1)
		begin
			wr(12'h000, k ? 32'h0000_0048 : 32'h0000_0044, 0);
			@(posedge aclk);
			flash_wr <= 1'b1;
			flash_wr_addr <= 18'h0_0200;
			flash_wr_data <= 8'hFF;
			@(posedge aclk);
			flash_wr <= 1'b0;
			wt(2);
			chk({pverify_mode, everify_mode, verify_dummy_seen},
				{k == 0, k == 1, 1'b1});
			chk(page_base, 18'h0_0200);
		end
		// The dummy writes left the latched unit untouched.
		@(posedge aclk);
		latch_rd_addr <= 7'h00;
		wt(3);
		chk(latch_rd_data, 8'hA5);
		wr(12'h000, 32'h0000_0042, 0);
		wt(2);
		chk(erase_active, 0);
		wr(12'h000, 32'h0000_0040, 0);
		wr(12'h00C, 32'h0000_0004, 0);
		wr(12'h000, 32'h0000_0042, 0);
		wt(2);
		chk({erase_active, erase_blocks}, {1'b1, 16'h0400});
		wr(12'h000, 32'h0000_0040, 0);
		wt(2);
		chk(erase_active, 0);
		// Overlay protection for program, erase and both bits set.
		wr(12'h010, 32'h0000_0008, 0);
		for (k = 1; k < 4; k = k + 1)
		begin
			wr(12'h000, 32'h0000_0040 | k, 0);
			wt(2);
			chk({prog_active, erase_active}, 0);
			wr(12'h000, 32'h0000_0040, 0);
		end
		wr(12'h010, 0, 0);
		// Protect pin, standby and a mid-run reset end programming.
		for (k = 0; k < 3; k = k + 1)
		begin
			wr(12'h000, 32'h0000_0041, 0);
			wt(2);
			chk(prog_active, 1);
			@(posedge aclk);
			write_protect_pin <= (k == 0);
			standby <= (k == 1);
			aresetn <= (k != 2);
			wt(6);
			chk(prog_active, 0);
			@(posedge aclk);
			write_protect_pin <= 1'b0;
			standby <= 1'b0;
			aresetn <= 1'b1;
			wt(3);
			rd(12'h000, 0, 0);
			rd(12'h00C, 0, 0);
		end
		// Each error event aborts and locks out until power-on reset.
		for (k = 0; k < 3; k = k + 1)
		begin
			rst(1);
			wr(12'h000, 32'h0000_0041, 0);
			ev(k);
			chk(prog_active, 0);
			rd(12'h004, 32'h0000_0080, 0);
			rd(12'h000, 32'h0000_0041, 0);
			wr(12'h000, 32'h0000_0040, 0);
			wr(12'h000, 32'h0000_0041, 0);
			wt(2);
			chk(prog_active, 0);
			wr(12'h000, 32'h0000_0044, 0);
			wt(2);
			chk(pverify_mode, 1);
			rst(0);
			rd(12'h004, 32'h0000_0080, 0);
		end
		rst(1);
		rd(12'h004, 0, 0);
		close_out;
	end
endmodule // tb
`default_nettype wire
